// ---- core/ahp_buf2.v ----
// Two-entry valid/ready buffer for conversion results heading to the host port.
`timescale 1ns/1ps
module ahp_buf2 (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Fill side
  input  wire        in_valid,
  output wire        in_ready,
  input  wire [15:0] in_data,
  // Drain side
  output wire        out_valid,
  input  wire        out_ready,
  output wire [15:0] out_data
);
  reg [15:0] mem_q [0:1];
  reg        wp_q;
  reg        rp_q;
  reg [1:0]  cnt_q;
  wire       push;
  wire       pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= 16'h0000;
      mem_q[1] <= 16'h0000;
    end
    else
    begin
      if (push)
      begin
        mem_q[wp_q] <= in_data;
        wp_q        <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      if (push & ~pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule // ahp_buf2

// ---- core/ahp_defs.vh ----
// Constants for the converter host-port and mode-select block.
`ifndef AHP_DEFS_VH
`define AHP_DEFS_VH
// AXI4-Lite register byte offsets.
`define AHP_CTRL_ADDR     5'h00
`define AHP_STATUS_ADDR   5'h04
`define AHP_CFG_ADDR      5'h08
`define AHP_RESULT_ADDR   5'h0c
`define AHP_PUSH_ADDR     5'h10
// Control word fields and reset value.
`define AHP_CW_RESET      32'h000003ff
`define AHP_CW_RANGE_A    26
`define AHP_CW_RANGE_B    27
`define AHP_CW_RANGE_C    28
`define AHP_CW_REF_ON     25
`define AHP_CW_DAC_MSB    9
// Configuration register fields.
`define AHP_CFG_VARIANT_LSB 0
`define AHP_VARIANT_16    2'h0
`define AHP_VARIANT_14    2'h1
`define AHP_VARIANT_12    2'h2
// AXI response codes.
`define AHP_RESP_OKAY     2'h0
`define AHP_RESP_SLVERR   2'h2
`endif

// ---- core/ahp_host_port.v ----
// Parallel host port, strap mode selection and control word of the converter.
// Function
// - Word mode: each result appears whole on all sixteen data lines, one access.
// - Byte mode: upper eight lines only, two accesses, byte order from select input.
// - Software mode: pair ranges A, B, C follow control bits 26, 27, 28.
// - Hardware mode: all pair ranges follow range pin, control bits ignored.
// - Hardware mode: reference-enable pin high turns internal reference and buffers on.
// - Software mode: internal reference follows control bit 25, pin ignored.
// - Reference level comes from ten-bit DAC code in control bits 9 to 0.
// - Interface select low picks parallel port, high picks serial.
// - Configuration source low uses pins, high uses internal control word.
// - Software parallel mode: data accepted only while chip select and write low.
// - 14-bit and 12-bit variants drive data bit 15 as zero.
// - Range low gives four times reference span, high gives twice.
// - Active-high reset aborts conversion and loads control word default.
`timescale 1ns/1ps
`include "ahp_defs.vh"
module ahp_host_port (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // AXI4-Lite write address and data
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Strap and mode pins
  input  wire        interface_select,
  input  wire        config_source_select,
  input  wire        range_select,
  input  wire        ref_on_or_write_strobe,
  input  wire        device_reset,
  // Parallel host pins
  input  wire        cs_n,
  input  wire        rd_n,
  input  wire        word_byte_select,
  input  wire        high_byte_first_select,
  input  wire [15:0] host_data_lines_in,
  output reg  [15:0] host_data_lines_out,
  output reg  [15:0] host_data_lines_oe,
  // Analog control outputs
  output reg  [2:0]  range_x2_pair,
  output reg         internal_ref_on,
  output reg  [9:0]  ref_dac_code,
  output reg         serial_mode,
  output reg         conv_abort
);
  localparam ST_IDLE = 3'b001;
  localparam ST_BYTE = 3'b010;
  localparam ST_WAIT = 3'b100;

  reg  [31:0] control_word_q;
  reg  [1:0]  variant_q;
  reg         strap_ser_q;
  reg         strap_sw_q;
  reg         strap_done_q;
  reg  [2:0]  st_q;
  reg         wr_cyc_q;
  reg         rd_cyc_q;
  reg  [15:0] cur_q;
  reg  [15:0] push_data_q;
  reg         push_valid_q;
  reg  [4:0]  awaddr_q;
  reg  [31:0] wdata_q;
  reg         aw_have_q;
  reg         w_have_q;
  reg  [31:0] rdata_d;
  wire        buf_in_ready;
  wire        buf_out_valid;
  wire [15:0] buf_out_data;
  wire        wr_act;
  wire        rd_act;
  wire        pop;
  wire        do_write;

  ahp_buf2 u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push_valid_q),
    .in_ready  (buf_in_ready),
    .in_data   (push_data_q),
    .out_valid (buf_out_valid),
    .out_ready (pop),
    .out_data  (buf_out_data)
  );

  // Zero bit 15 on the narrower variants; their results sit below it.
  function [15:0] fix_msb;
    input [15:0] v;
    input [1:0]  vsel;
    begin
      fix_msb = v;
      if (vsel != `AHP_VARIANT_16)
        fix_msb[15] = 1'b0;
    end
  endfunction

  // --------------------------------------------------------------------
  // Strap capture
  // --------------------------------------------------------------------
  // Straps are caught once after reset release, so no mode change can
  // tear a transfer in half.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_done_q <= 1'b0;
      strap_ser_q  <= 1'b0;
      strap_sw_q   <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      strap_done_q <= 1'b1;
      strap_ser_q  <= interface_select;
      strap_sw_q   <= config_source_select;
    end
  end

  assign wr_act = strap_done_q & ~strap_ser_q & strap_sw_q
                  & ~cs_n & ~ref_on_or_write_strobe;
  assign rd_act = strap_done_q & ~strap_ser_q & ~cs_n & ~rd_n;
  assign pop    = (st_q == ST_IDLE) & rd_act & ~rd_cyc_q & buf_out_valid
                  & ~device_reset;

  // --------------------------------------------------------------------
  // Parallel read sequencer
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q                <= ST_IDLE;
      rd_cyc_q            <= 1'b0;
      cur_q               <= 16'h0000;
      host_data_lines_out <= 16'h0000;
      host_data_lines_oe  <= 16'h0000;
    end
    else
    begin
      rd_cyc_q <= rd_act;
      if (!rd_act)
        host_data_lines_oe <= 16'h0000;
      if (device_reset)
        st_q <= ST_IDLE;
      else
      begin
        case (st_q)
          ST_IDLE:
          begin
            if (pop)
            begin
              cur_q <= fix_msb(buf_out_data, variant_q);
              if (!word_byte_select)
              begin
                host_data_lines_out <= fix_msb(buf_out_data, variant_q);
                host_data_lines_oe  <= 16'hffff;
                st_q                <= ST_WAIT;
              end
              else
              begin
                host_data_lines_out <= high_byte_first_select ?
                  {buf_out_data[15:8], 8'h00} : {buf_out_data[7:0], 8'h00};
                host_data_lines_oe  <= 16'hff00;
                st_q                <= ST_BYTE;
              end
              if (!word_byte_select && variant_q != `AHP_VARIANT_16)
                host_data_lines_out[15] <= 1'b0;
              else if (word_byte_select && high_byte_first_select
                       && variant_q != `AHP_VARIANT_16)
                host_data_lines_out[15] <= 1'b0;
            end
          end
          ST_BYTE:
          begin
            // Second access of the pair carries the other byte.
            if (rd_act && !rd_cyc_q)
            begin
              host_data_lines_out <= high_byte_first_select ?
                {cur_q[7:0], 8'h00} : {cur_q[15:8], 8'h00};
              host_data_lines_oe  <= 16'hff00;
              st_q                <= ST_WAIT;
            end
          end
          ST_WAIT:
          begin
            if (!rd_act)
              st_q <= ST_IDLE;
          end
          default:
            st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------
  assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AHP_RESP_OKAY;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 5'h00;
      wdata_q       <= 32'h00000000;
      push_valid_q  <= 1'b0;
      push_data_q   <= 16'h0000;
      variant_q     <= `AHP_VARIANT_16;
      control_word_q <= `AHP_CW_RESET;
    end
    else
    begin
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
      end
      if (push_valid_q && buf_in_ready)
        push_valid_q <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_write)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `AHP_RESP_OKAY;
        case (awaddr_q)
          `AHP_CTRL_ADDR:
            if (strap_sw_q && !wr_act)
              control_word_q <= wdata_q;
          `AHP_CFG_ADDR:
            variant_q <= wdata_q[`AHP_CFG_VARIANT_LSB+1:`AHP_CFG_VARIANT_LSB];
          `AHP_PUSH_ADDR:
            if (!push_valid_q)
            begin
              push_valid_q <= 1'b1;
              push_data_q  <= wdata_q[15:0];
            end
            else
              s_axi_bresp <= `AHP_RESP_SLVERR;
          default:
            s_axi_bresp <= `AHP_RESP_SLVERR;
        endcase
      end
      // Host-pin writes take priority over bus writes in the same cycle.
      if (wr_act)
        control_word_q[15:0] <= host_data_lines_in;
      if (device_reset)
        control_word_q <= `AHP_CW_RESET;
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------
  always @*
  begin
    rdata_d = 32'h00000000;
    case (s_axi_araddr)
      `AHP_CTRL_ADDR:   rdata_d = control_word_q;
      `AHP_STATUS_ADDR: rdata_d = {24'h000000, st_q, buf_out_valid, buf_in_ready,
                                   strap_done_q, strap_sw_q, strap_ser_q};
      `AHP_CFG_ADDR:    rdata_d = {30'h00000000, variant_q};
      `AHP_RESULT_ADDR: rdata_d = {16'h0000, cur_q};
      default:          rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `AHP_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
      begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdata_d;
        s_axi_rresp   <= (s_axi_araddr == `AHP_PUSH_ADDR || s_axi_araddr[1:0] != 2'h0
                          || s_axi_araddr > `AHP_PUSH_ADDR) ? `AHP_RESP_SLVERR
                                                             : `AHP_RESP_OKAY;
      end
    end
  end

  // --------------------------------------------------------------------
  // Mode-dependent analog control
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      range_x2_pair   <= 3'h0;
      internal_ref_on <= 1'b0;
      ref_dac_code    <= 10'h3ff;
      serial_mode     <= 1'b0;
      conv_abort      <= 1'b0;
    end
    else
    begin
      serial_mode  <= strap_ser_q;
      conv_abort   <= device_reset;
      ref_dac_code <= control_word_q[`AHP_CW_DAC_MSB:0];
      // A set bit selects the twice-reference span, clear the four-times span.
      if (strap_sw_q)
      begin
        range_x2_pair <= {control_word_q[`AHP_CW_RANGE_C],
                          control_word_q[`AHP_CW_RANGE_B],
                          control_word_q[`AHP_CW_RANGE_A]};
        internal_ref_on <= control_word_q[`AHP_CW_REF_ON];
      end
      else
      begin
        range_x2_pair   <= {3{range_select}};
        internal_ref_on <= ref_on_or_write_strobe;
      end
    end
  end
endmodule // ahp_host_port

// ---- test/ahp_host_model.sv ----
// Host model that reads and writes the parallel port.
`timescale 1ns/1ps
module ahp_host_model (
  // Clock
  input  wire        clk,
  // Device side of the lines
  input  wire [15:0] dout,
  input  wire [15:0] doe,
  // Host strobes and resolved lines
  output reg         cs_n,
  output reg         rd_n,
  output reg         wr_n,
  output wire [15:0] line
);
  reg        host_oe = 1'b0;
  reg [15:0] din     = 16'h0000;
  reg [15:0] last_q  = 16'h0000;
  // ------------------------------------------------------------
  // Lines and strobes
  // ------------------------------------------------------------
  // Undriven lines show the inverse of their last level, so stale data never passes.
  assign line = host_oe ? din : ((doe & dout) | (~doe & ~last_q));
  always @(posedge clk) last_q <= line;
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
  end
  task automatic rd(input [3:0] slow, output [15:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (3 + slow) @(posedge clk);
    d = line;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
  endtask
  task automatic wr(input sel, input [15:0] v);
    @(posedge clk);
    cs_n <= ~sel;
    wr_n <= 1'b0;
    host_oe <= 1'b1;
    din <= v;
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    host_oe <= 1'b0;
  endtask
  task automatic set_pin(input v);
    @(posedge clk);
    wr_n <= v;
  endtask
endmodule // ahp_host_model

// ---- test/ahp_host_port_properties.sv ----
// Concurrent checks on the ports of the converter host-port block.
`timescale 1ns/1ps
module ahp_host_port_props (
  input wire        clk,
  input wire        rst_n,
  input wire        s_axi_awready,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        cs_n,
  input wire        rd_n,
  input wire        word_byte_select,
  input wire [15:0] host_data_lines_oe,
  input wire        serial_mode,
  input wire        device_reset,
  input wire        conv_abort,
  input wire [9:0]  ref_dac_code
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence seq_release;
    $rose(cs_n) || $rose(rd_n);
  endsequence
  sequence seq_held_reset;
    device_reset ##1 device_reset;
  endsequence
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
  r_answer_a: assert property (s_axi_arready |-> s_axi_rvalid)
    else $error("arready without rvalid");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid after handshake");
  bus_release_a: assert property (seq_release |=> host_data_lines_oe == 16'h0000)
    else $error("lines still driven after release");
  low_byte_a: assert property (word_byte_select && $past(word_byte_select) |-> host_data_lines_oe[7:0] == 8'h00)
    else $error("low byte driven in byte mode");
  serial_quiet_a: assert property (serial_mode |-> host_data_lines_oe == 16'h0000)
    else $error("parallel lines driven in serial mode");
  dac_default_a: assert property (seq_held_reset |=> ref_dac_code == 10'h3ff)
    else $error("dac code not default after reset");
  abort_follow_a: assert property (conv_abort == $past(device_reset))
    else $error("abort does not follow reset");
  mode_static_a: assert property (!cs_n && !rd_n |=> $stable(serial_mode))
    else $error("mode changed during access");
endmodule // ahp_host_port_props
bind ahp_host_port ahp_host_port_props i_props (.clk(clk), .rst_n(rst_n),
  .s_axi_awready(s_axi_awready), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cs_n(cs_n), .rd_n(rd_n),
  .word_byte_select(word_byte_select), .host_data_lines_oe(host_data_lines_oe),
  .serial_mode(serial_mode), .device_reset(device_reset), .conv_abort(conv_abort),
  .ref_dac_code(ref_dac_code));

// ---- test/ahp_host_port_tb_top.sv ----
// Self-checking bench for the converter host-port block.
`timescale 1ns/1ps
`include "ahp_defs.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module ahp_host_port_tb_top;
  reg clk = 0, rst_n = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  reg ifsel = 0, cfgsel = 1, rsel = 0, dres = 0, wbs = 0, hbf = 0;
  reg [4:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0, rv;
  reg [15:0] d, d2;
  reg [1:0] rs;
  wire awready, wready, bvalid, arready, rvalid, cs_n, rd_n, wr_n, refon, ser, abrt;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] line, dout, doe;
  wire [2:0] rng;
  wire [9:0] dac;
  int bad_count = 0, check_count = 0;
  always #5 clk = ~clk;
  ahp_host_port i_dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .interface_select(ifsel), .config_source_select(cfgsel), .range_select(rsel),
    .ref_on_or_write_strobe(wr_n), .device_reset(dres), .cs_n(cs_n), .rd_n(rd_n),
    .word_byte_select(wbs), .high_byte_first_select(hbf), .host_data_lines_in(line),
    .host_data_lines_out(dout), .host_data_lines_oe(doe), .range_x2_pair(rng),
    .internal_ref_on(refon), .ref_dac_code(dac), .serial_mode(ser), .conv_abort(abrt));
  ahp_host_model i_host (.clk(clk), .dout(dout), .doe(doe), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .line(line));
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task automatic axw(input [4:0] a, input [31:0] v, output [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    while (n < 40)
    begin
      @(posedge clk);
      n++;
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n >= 40) bad_count++;
  endtask
  task automatic axr(input [4:0] a, output [31:0] v, output [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    while (n < 40)
    begin
      @(posedge clk);
      n++;
      if (arready) arv <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 40) bad_count++;
  endtask
  // A fresh reset is the only way to move the straps, which are captured once.
  task automatic reboot(input sw, input sr);
    @(posedge clk);
    rst_n <= 1'b0;
    cfgsel <= sw;
    ifsel <= sr;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    axr(`AHP_CTRL_ADDR, rv, rs);
    `CHK(rv, `AHP_CW_RESET)
    `CHK(dac, 10'h3ff)
  endtask
  task automatic t_ctrl;
    reg [31:0] w [2];
    w = '{32'h14000155, 32'h0a0002aa};
    for (int i = 0; i < 2; i++)
    begin
      axw(`AHP_CTRL_ADDR, w[i], rs);
      repeat (2) @(posedge clk);
      `CHK(rng, {w[i][28], w[i][27], w[i][26]})
      `CHK(refon, w[i][25])
      `CHK(dac, w[i][9:0])
    end
  endtask
  task automatic t_pin_write;
    i_host.wr(1'b1, 16'h0123);
    repeat (2) @(posedge clk);
    `CHK(dac, 10'h123)
    i_host.wr(1'b0, 16'h0321);
    repeat (2) @(posedge clk);
    `CHK(dac, 10'h123)
    i_host.set_pin(1'b0);
    repeat (2) @(posedge clk);
    `CHK(refon, 1'b1)
    i_host.set_pin(1'b1);
  endtask
  task automatic t_word;
    axw(`AHP_PUSH_ADDR, 32'h0000a5c3, rs);
    axw(`AHP_PUSH_ADDR, 32'h00003c5a, rs);
    axr(`AHP_STATUS_ADDR, rv, rs);
    `CHK(rv[3], 1'b0)
    i_host.rd(4'h0, d);
    `CHK(d, 16'ha5c3)
    i_host.rd(4'h3, d);
    `CHK(d, 16'h3c5a)
    axr(`AHP_STATUS_ADDR, rv, rs);
    `CHK(rv[4], 1'b0)
  endtask
  task automatic t_byte;
    wbs <= 1'b1;
    for (int hb = 0; hb < 2; hb++)
    begin
      hbf <= hb[0];
      axw(`AHP_PUSH_ADDR, 32'h00009e17, rs);
      i_host.rd(4'h0, d);
      i_host.rd(4'h1, d2);
      `CHK({d[15:8], d2[15:8]}, hb ? 16'h9e17 : 16'h179e)
    end
    @(posedge clk);
    wbs <= 1'b0;
  endtask
  task automatic t_variant;
    for (int v = 1; v < 3; v++)
    begin
      axw(`AHP_CFG_ADDR, v, rs);
      axw(`AHP_PUSH_ADDR, 32'h0000ffff, rs);
      i_host.rd(4'h0, d);
      `CHK(d, 16'h7fff)
    end
    wbs <= 1'b1;
    hbf <= 1'b1;
    axw(`AHP_PUSH_ADDR, 32'h0000ffff, rs);
    i_host.rd(4'h0, d);
    i_host.rd(4'h0, d2);
    `CHK({d[15:8], d2[15:8]}, 16'h7fff)
    wbs <= 1'b0;
    axw(`AHP_CFG_ADDR, 32'h0, rs);
  endtask
  task automatic t_bad_addr;
    axr(5'h14, rv, rs);
    `CHK(rs, `AHP_RESP_SLVERR)
    axw(5'h06, 32'h1, rs);
    `CHK(rs, `AHP_RESP_SLVERR)
  endtask
  task automatic t_dev_reset;
    axw(`AHP_CTRL_ADDR, 32'h0, rs);
    @(posedge clk);
    dres <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(abrt, 1'b1)
    dres <= 1'b0;
    axr(`AHP_CTRL_ADDR, rv, rs);
    `CHK(rv, `AHP_CW_RESET)
  endtask
  task automatic t_hw;
    reboot(1'b0, 1'b0);
    rsel <= 1'b1;
    i_host.set_pin(1'b1);
    axw(`AHP_CTRL_ADDR, 32'h0, rs);
    repeat (2) @(posedge clk);
    `CHK({rng, refon, ser}, 5'b11110)
    rsel <= 1'b0;
    i_host.set_pin(1'b0);
    repeat (2) @(posedge clk);
    `CHK({rng, refon}, 4'b0000)
    reboot(1'b1, 1'b1);
    `CHK(ser, 1'b1)
    axw(`AHP_PUSH_ADDR, 32'h00001111, rs);
    i_host.rd(4'h0, d);
    `CHK(doe, 16'h0000)
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_ctrl;
    t_pin_write;
    t_word;
    t_byte;
    t_variant;
    t_bad_addr;
    t_dev_reset;
    t_hw;
    wrap_up;
  end
  initial
  begin
    #300000;
    bad_count++;
    wrap_up;
  end
endmodule // ahp_host_port_tb_top
